// ===== fdp_pkg.sv
// Constants for the strobed field data port
`default_nettype none
package fdp_pkg;
   // ==========================================
   // Clock
   localparam int unsigned CLK_MHZ           = 25;
   // ==========================================
   // Pin modes
   localparam logic [1:0]  MODE_INPUT        = 2'h0;
   localparam logic [1:0]  MODE_OUTPUT       = 2'h1;
   localparam logic [1:0]  MODE_OUTIN        = 2'h2;
   // ==========================================
   // Times in ns
   localparam int unsigned STROBE_TO_VALID_DELAY_NS = 1500;
   localparam int unsigned STROBE_WIDTH_MIN_NS      = 6000;
   localparam int unsigned STROBE_WIDTH_MAX_NS      = 6800;
   localparam int unsigned STROBE_WIDTH_NS          = 6400;
   localparam int unsigned OUT_HOLD_MIN_NS          = 400;
   localparam int unsigned RELEASE_MIN_NS           = 200;
   localparam int unsigned RELEASE_MAX_NS           = 1000;
   localparam int unsigned RELEASE_NS               = 600;
   localparam int unsigned INPUT_SAMPLE_WINDOW_MIN_NS = 10500;
   localparam int unsigned INPUT_SAMPLE_WINDOW_MAX_NS = 12500;
   localparam int unsigned SAMPLE_NS                = 11500;
   // Times in ms
   localparam int unsigned LONG_LOW_RESET_WIDTH_MS  = 100;
   localparam int unsigned NO_RESET_WIDTH_MS        = 50;
   // ==========================================
   // Cycle counts, counter width and FIFO depth
   localparam int unsigned STROBE_TO_VALID_CYC = (STROBE_TO_VALID_DELAY_NS * CLK_MHZ) / 1000;
   localparam int unsigned STB_LOW_CYC  = (STROBE_WIDTH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RELEASE_CYC  = (RELEASE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SAMPLE_CYC   = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned LONG_LOW_CYC = LONG_LOW_RESET_WIDTH_MS * 1000 * CLK_MHZ;
   localparam int unsigned CNT_W        = 9;
   localparam int unsigned FIFO_DEPTH   = 8;
   // ==========================================
   // Engine states
   typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} fdp_state_type;
endpackage : fdp_pkg
`default_nettype wire

// ===== fdp_stream_if.sv
// Valid/ready word stream between the port's own modules
`timescale 1ns/1ps
`default_nettype none
interface fdp_stream_if #(parameter int unsigned W = 4);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : fdp_stream_if
`default_nettype wire

// ===== fdp_fifo.sv
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fdp_fifo #(
   parameter int unsigned W     = 4,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic     clk,
   input  wire logic     rst_n,
   fdp_stream_if.snk     inPort,
   fdp_stream_if.src     outPort
);
   localparam int unsigned AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gBadDepth
         $error("fdp_fifo depth must be a power of two of at least 2");
      end
   endgenerate

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wrPtr_q;
   logic [AW:0]  rdPtr_q;
   wire          empty = (wrPtr_q == rdPtr_q);
   wire          full  = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
   wire          push  = inPort.valid && !full;
   wire          pop   = outPort.ready && !empty;

   assign inPort.ready  = !full;
   assign outPort.valid = !empty;
   assign outPort.data  = mem[rdPtr_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q[AW-1:0]] <= inPort.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (push) wrPtr_q <= wrPtr_q + 1'b1;
         if (pop)  rdPtr_q <= rdPtr_q + 1'b1;
      end
   end
endmodule : fdp_fifo
`default_nettype wire

// ===== fdp_field_port.sv
// Strobed four-bit field data port with long-low reset sensing
//
// Summary of operation
// - Each of the four data pins is set on its own to output, output/input or input by its configuration code.
// - An output pin has valid data within 1.5 us of the strobe falling edge and holds it to the next falling edge.
// - An output/input pin drives from the strobe fall through its rise and is released 0.2 to 1 us after the rise.
// - Input and output/input pins are sampled inside the 10.5 to 12.5 us window after the strobe fall.
// - Each strobe low pulse lasts 6 to 6.8 us and ends by releasing the pin.
// - Driven data stays valid at least 0.4 us after the strobe rise.
// - A strobe held low from outside for 100 ms resets the device; lows of 50 ms or less do not.
// - The strobe only pulls low and is released to a weak pull-up, so it can be read back.
// - Data pins only drive low or float; the pull-up is outside.
`timescale 1ns/1ps
`default_nettype none
module fdp_field_port #(
   parameter int unsigned LONG_LOW_CYCLES = fdp_pkg::LONG_LOW_CYC,
   parameter int unsigned FIFO_DEPTH      = fdp_pkg::FIFO_DEPTH
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] pinMode,
   input  wire logic       reqValid,
   output logic            reqReady,
   input  wire logic [3:0] reqData,
   output logic            rspValid,
   output logic [3:0]      rspData,
   input  wire logic       fieldStrobeNIn,
   output logic            fieldStrobeNOut,
   output logic            fieldStrobeNOe,
   input  wire logic [3:0] fieldBitIn,
   output logic [3:0]      fieldBitOut,
   output logic [3:0]      fieldBitOe,
   output logic            longLowReset
);
   localparam int unsigned CW = fdp_pkg::CNT_W;
   localparam logic [CW-1:0] LOW_END  = CW'(fdp_pkg::STB_LOW_CYC - 1);
   localparam logic [CW-1:0] REL_END  = CW'(fdp_pkg::STB_LOW_CYC + fdp_pkg::RELEASE_CYC - 1);
   localparam logic [CW-1:0] SMP_END  = CW'(fdp_pkg::SAMPLE_CYC - 1);

   generate
      if (LONG_LOW_CYCLES < 2 || fdp_pkg::SAMPLE_CYC >= (1 << CW)) begin : gBadParam
         $error("fdp_field_port timing parameters out of range");
      end
   endgenerate

   // ==========================================
   // Chosen timing points must sit inside their windows
   localparam int unsigned LOW_NS = (fdp_pkg::STB_LOW_CYC * 1000) / fdp_pkg::CLK_MHZ;
   localparam int unsigned REL_NS = (fdp_pkg::RELEASE_CYC * 1000) / fdp_pkg::CLK_MHZ;
   // Captured value is the pin level two clocks earlier
   localparam int unsigned SMP_NS = ((fdp_pkg::SAMPLE_CYC - 2) * 1000) / fdp_pkg::CLK_MHZ;
   localparam bit          LOW_OK = (LOW_NS >= fdp_pkg::STROBE_WIDTH_MIN_NS) &&
                                    (LOW_NS <= fdp_pkg::STROBE_WIDTH_MAX_NS);
   localparam bit          REL_OK = (REL_NS >= fdp_pkg::RELEASE_MIN_NS) &&
                                    (REL_NS <= fdp_pkg::RELEASE_MAX_NS) &&
                                    (REL_NS >= fdp_pkg::OUT_HOLD_MIN_NS);
   localparam bit          SMP_OK = (SMP_NS >= fdp_pkg::INPUT_SAMPLE_WINDOW_MIN_NS) &&
                                    (SMP_NS <= fdp_pkg::INPUT_SAMPLE_WINDOW_MAX_NS);

   generate
      if (!LOW_OK) begin : gBadWidth
         $error("fdp_field_port strobe width outside its window");
      end
      if (!REL_OK) begin : gBadRelease
         $error("fdp_field_port output/input release point outside its window");
      end
      if (!SMP_OK) begin : gBadSample
         $error("fdp_field_port input sample point outside its window");
      end
   endgenerate

   // ==========================================
   // Request FIFO
   fdp_stream_if #(.W(4)) reqIf ();
   fdp_stream_if #(.W(4)) popIf ();

   assign reqIf.valid = reqValid;
   assign reqIf.data  = reqData;
   assign reqReady    = reqIf.ready;

   fdp_fifo #(.W(4), .DEPTH(FIFO_DEPTH)) uFifo (
      .clk     (clk),
      .rst_n   (rst_n),
      .inPort  (reqIf),
      .outPort (popIf)
   );

   // ==========================================
   // Pin synchronisers
   logic       strobeMeta_q;
   logic       strobeSync_q;
   logic [3:0] bitMeta_q;
   logic [3:0] bitSync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobeMeta_q <= 1'b1;
         strobeSync_q <= 1'b1;
         bitMeta_q    <= 4'hF;
         bitSync_q    <= 4'hF;
      end else begin
         strobeMeta_q <= fieldStrobeNIn;
         strobeSync_q <= strobeMeta_q;
         bitMeta_q    <= fieldBitIn;
         bitSync_q    <= bitMeta_q;
      end
   end

   // ==========================================
   // Strobe engine
   fdp_pkg::fdp_state_type state_q;
   fdp_pkg::fdp_state_type state_d;
   logic [CW-1:0] cnt_q;
   logic [3:0]    outData_q;
   logic          ioDrive_q;
   logic          strobeLow_q;
   logic          longLow_q;

   wire           startCycle = (state_q == fdp_pkg::ST_IDLE) && popIf.valid && !longLow_q;
   wire           lowDone    = (state_q == fdp_pkg::ST_LOW) && (cnt_q == LOW_END);
   wire           releaseIo  = (state_q == fdp_pkg::ST_HIGH) && (cnt_q == REL_END);
   wire           sampleNow  = (state_q == fdp_pkg::ST_HIGH) && (cnt_q == SMP_END);

   assign popIf.ready = startCycle;

   always_comb begin
      state_d = state_q;
      case (state_q)
         fdp_pkg::ST_IDLE: begin
            if (startCycle) state_d = fdp_pkg::ST_LOW;
         end
         fdp_pkg::ST_LOW: begin
            if (lowDone) state_d = fdp_pkg::ST_HIGH;
         end
         fdp_pkg::ST_HIGH: begin
            if (sampleNow) state_d = fdp_pkg::ST_IDLE;
         end
         default: state_d = fdp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= fdp_pkg::ST_IDLE;
         cnt_q   <= '0;
      end else if (longLow_q) begin
         state_q <= fdp_pkg::ST_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= (state_d == fdp_pkg::ST_IDLE || startCycle) ? '0 : cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outData_q   <= 4'hF;
         ioDrive_q   <= 1'b0;
         strobeLow_q <= 1'b0;
      end else if (longLow_q) begin
         ioDrive_q   <= 1'b0;
         strobeLow_q <= 1'b0;
      end else begin
         if (startCycle) outData_q <= popIf.data;
         if (startCycle) ioDrive_q <= 1'b1;
         else if (releaseIo) ioDrive_q <= 1'b0;
         if (startCycle) strobeLow_q <= 1'b1;
         else if (lowDone) strobeLow_q <= 1'b0;
      end
   end

   // ==========================================
   // Pin drivers: low drive or float only
   assign fieldStrobeNOut = 1'b0;
   assign fieldStrobeNOe  = strobeLow_q;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : gPin
         wire [1:0] mode     = pinMode[2*gi +: 2];
         wire       isOut    = (mode == fdp_pkg::MODE_OUTPUT);
         wire       isOutIn  = (mode == fdp_pkg::MODE_OUTIN);
         wire       drive    = isOut || (isOutIn && ioDrive_q);
         assign fieldBitOut[gi] = 1'b0;
         assign fieldBitOe[gi]  = drive && !outData_q[gi];
      end
   endgenerate

   // ==========================================
   // Response capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rspValid <= 1'b0;
         rspData  <= 4'h0;
      end else begin
         rspValid <= sampleNow && !longLow_q;
         if (sampleNow) rspData <= bitSync_q;
      end
   end

   // ==========================================
   // Long external low detection, only while the strobe is released
   logic [31:0] lowCnt_q;
   wire         extLow = !strobeSync_q && !strobeLow_q && (state_q != fdp_pkg::ST_LOW);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt_q  <= '0;
         longLow_q <= 1'b0;
      end else if (!extLow) begin
         lowCnt_q  <= '0;
         longLow_q <= 1'b0;
      end else begin
         if (lowCnt_q != 32'(LONG_LOW_CYCLES)) lowCnt_q <= lowCnt_q + 1'b1;
         if (lowCnt_q == 32'(LONG_LOW_CYCLES - 1)) longLow_q <= 1'b1;
      end
   end

   assign longLowReset = longLow_q;
endmodule : fdp_field_port
`default_nettype wire

// ===== fdp_port_asserts.sv
// Assertion checker for the field data port
`timescale 1ns/1ps
`default_nettype none
module fdp_port_asserts #(parameter int unsigned LONG_LOW_CYCLES = 50) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [7:0] pinMode,
   input wire logic       rspValid,
   input wire logic       fieldStrobeNIn,
   input wire logic       fieldStrobeNOut,
   input wire logic       fieldStrobeNOe,
   input wire logic [3:0] fieldBitOut,
   input wire logic [3:0] fieldBitOe,
   input wire logic       longLowReset
);
   // ======
   // Helpers
   logic [7:0]  wid_q;
   logic [31:0] low_q;
   logic [3:0]  outM;
   logic [3:0]  ioM;
   for (genvar i = 0; i < 4; i++) begin : g_m
      assign outM[i] = pinMode[2*i+:2] == fdp_pkg::MODE_OUTPUT;
      assign ioM[i]  = pinMode[2*i+:2] == fdp_pkg::MODE_OUTIN;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wid_q <= 8'h00;
         low_q <= 32'h0;
      end else begin
         wid_q <= fieldStrobeNOe ? wid_q + 8'h01 : 8'h00;
         low_q <= (fieldStrobeNIn || fieldStrobeNOe) ? 32'h0 : low_q + 32'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ======
   // Properties
   property p_wid; $fell(fieldStrobeNOe) |-> wid_q >= 8'h96 && wid_q <= 8'hAA; endproperty
   a_wid: assert property (p_wid) else $error("strobe width");
   property p_spull; fieldStrobeNOut == 1'b0; endproperty
   a_spull: assert property (p_spull) else $error("strobe high drive");
   property p_dpull; fieldBitOut == 4'h0; endproperty
   a_dpull: assert property (p_dpull) else $error("data high drive");
   property p_io;
      $fell(fieldStrobeNOe) |-> $stable(fieldBitOe & ioM)[*8] ##1 $stable(fieldBitOe & ioM)[*2]
         ##[1:15] ((fieldBitOe & ioM) == 4'h0);
   endproperty
   a_io: assert property (p_io) else $error("outin release");
   property p_out; !$rose(fieldStrobeNOe) && $stable(pinMode) |-> $stable(fieldBitOe & outM); endproperty
   a_out: assert property (p_out) else $error("output moved");
   property p_smp; $rose(fieldStrobeNOe) |-> ##[287:289] rspValid; endproperty
   a_smp: assert property (p_smp) else $error("sample time");
   property p_pls; rspValid |=> !rspValid; endproperty
   a_pls: assert property (p_pls) else $error("sample pulse");
   property p_llmin; $rose(longLowReset) |-> low_q >= LONG_LOW_CYCLES; endproperty
   a_llmin: assert property (p_llmin) else $error("early reset");
   property p_llmax; low_q == LONG_LOW_CYCLES + 8 |-> longLowReset; endproperty
   a_llmax: assert property (p_llmax) else $error("late reset");
endmodule : fdp_port_asserts
bind fdp_field_port fdp_port_asserts #(.LONG_LOW_CYCLES(LONG_LOW_CYCLES)) u_asserts (.clk(clk), .rst_n(rst_n),
   .pinMode(pinMode), .rspValid(rspValid), .fieldStrobeNIn(fieldStrobeNIn), .fieldStrobeNOut(fieldStrobeNOut),
   .fieldStrobeNOe(fieldStrobeNOe), .fieldBitOut(fieldBitOut), .fieldBitOe(fieldBitOe), .longLowReset(longLowReset));
`default_nettype wire

// ===== fdp_field_model.sv
// Sensors and actuators on the field side
`timescale 1ns/1ps
`default_nettype none
module fdp_field_model (
   input  wire logic       fieldStrobeNOe,
   input  wire logic [3:0] fieldBitOe,
   input  wire logic       holdLow,
   input  wire logic [3:0] sensData,
   output logic            fieldStrobeNIn,
   output logic [3:0]      fieldBitIn,
   output logic [3:0]      latched
);
   realtime tFall = -1.0e6;
   logic    sensOn = 1'b0;
   // Weak pull-up on the strobe wire
   assign fieldStrobeNIn = !(fieldStrobeNOe || holdLow);
   // Open-drain lines, pull-up outside
   assign fieldBitIn = ~fieldBitOe & (sensOn ? sensData : 4'hF);
   always @(negedge fieldStrobeNIn) tFall = $realtime;
   // Sensors pull only inside their window
   always #50 sensOn = ($realtime - tFall >= 10400) && ($realtime - tFall <= 12600);
   // Actuators latch on the strobe rise, no added delay
   always @(posedge fieldStrobeNIn) latched = fieldBitIn;
endmodule : fdp_field_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the field data port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int unsigned LL = 50;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] pinMode = 8'h00;
   logic       reqValid = 1'b0;
   logic [3:0] reqData = 4'h0;
   logic       holdLow = 1'b0;
   logic [3:0] sensData = 4'hF;
   logic       reqReady, rspValid, sIn, sOut, sOe, longLowReset;
   logic [3:0] rspData, bIn, bOut, bOe, latched;
   int         bad_count = 0;
   int         comparisons = 0;
   int         n;
   // Mode, request, sensors, sampled, latched
   logic [23:0] rows [5] = '{24'h55AFAA, 24'hAA5335, 24'h00C66F, 24'hE40999, 24'h1B0FB9};
   always #20 clk = ~clk;
   fdp_field_port #(.LONG_LOW_CYCLES(LL)) uut (.clk(clk), .rst_n(rst_n), .pinMode(pinMode), .reqValid(reqValid),
      .reqReady(reqReady), .reqData(reqData), .rspValid(rspValid), .rspData(rspData), .fieldStrobeNIn(sIn),
      .fieldStrobeNOut(sOut), .fieldStrobeNOe(sOe), .fieldBitIn(bIn), .fieldBitOut(bOut), .fieldBitOe(bOe),
      .longLowReset(longLowReset));
   fdp_field_model u_field (.fieldStrobeNOe(sOe), .fieldBitOe(bOe), .holdLow(holdLow), .sensData(sensData),
      .fieldStrobeNIn(sIn), .fieldBitIn(bIn), .latched(latched));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic push(input logic [3:0] d);
      @(negedge clk);
      reqValid = 1'b1;
      reqData  = d;
      @(posedge clk);
      while (reqReady !== 1'b1) @(posedge clk);
   endtask : push
   task automatic waitRsp();
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rspValid !== 1'b1 && n < 400);
      if (n >= 400) check(1'b0, 1'b1);
   endtask : waitRsp
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   initial begin
      #800000;
      bad_count++;
      summarize();
   end
   initial begin
      repeat (8) @(negedge clk);
      check({reqReady, rspValid, rspData, sOe, bOe, longLowReset}, 12'h800);
      rst_n = 1'b1;
      for (int r = 0; r < 5; r++) begin
         pinMode  = rows[r][23:16];
         sensData = rows[r][11:8];
         push(rows[r][15:12]);
         @(negedge clk);
         reqValid = 1'b0;
         waitRsp();
         check(rspData, rows[r][7:4]);
         check(latched, rows[r][3:0]);
      end
      // Fill the queue until it refuses, then drain
      pinMode = 8'h55;
      for (int k = 0; k < 9; k++) push(k[3:0]);
      @(negedge clk);
      check(reqReady, 1'b0);
      reqValid = 1'b0;
      for (int k = 0; k < 9; k++) waitRsp();
      check(latched, 4'h8);
      // Short low, then long low with a request waiting
      holdLow = 1'b1;
      repeat (LL - 10) @(negedge clk);
      check(longLowReset, 1'b0);
      holdLow = 1'b0;
      repeat (5) @(negedge clk);
      holdLow = 1'b1;
      repeat (LL + 10) @(negedge clk);
      check(longLowReset, 1'b1);
      push(4'h3);
      @(negedge clk);
      reqValid = 1'b0;
      repeat (300) @(negedge clk);
      check({sOe, longLowReset}, 2'h1);
      holdLow = 1'b0;
      repeat (6) @(negedge clk);
      check(longLowReset, 1'b0);
      waitRsp();
      check(latched, 4'h3);
      // Reset in mid-cycle aborts the strobe
      push(4'h6);
      @(negedge clk);
      reqValid = 1'b0;
      repeat (100) @(negedge clk);
      check({sOe, bOe}, 5'h19);
      rst_n = 1'b0;
      @(negedge clk);
      check({reqReady, rspValid, sOe, bOe, longLowReset}, 8'h80);
      rst_n = 1'b1;
      push(4'h9);
      @(negedge clk);
      reqValid = 1'b0;
      waitRsp();
      check(rspData, 4'h9);
      check(latched, 4'h9);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
